// ### pkg/csr_pkg.sv
// Constants, types and carriers for the core status register block
`default_nettype none
package csr_pkg;

   // Bus geometry and the register map
   localparam int AXI_ADDR_W = 8;
   localparam int AXI_DATA_W = 32;
   localparam logic [AXI_ADDR_W-1:0] CORE_STATUS_ADDR = 8'h00;
   localparam logic [1:0] AXI_RESP_OKAY = 2'h0;
   localparam logic [1:0] AXI_RESP_SLVERR = 2'h2;

   // Field positions inside core_status
   localparam int WAKE_BIT = 7;
   localparam int PAGE_HI_BIT = 6;
   localparam int PAGE_LO_BIT = 5;
   localparam int TIMEOUT_BIT = 4;
   localparam int POWERDOWN_BIT = 3;
   localparam int ZERO_BIT = 2;
   localparam int NIBBLE_BIT = 1;
   localparam int CARRY_BIT = 0;

   // Power-up value; unknown ALU flags start at zero
   localparam logic [7:0] CORE_STATUS_RESET = 8'h18;
   // Bits that a plain register write may change
   localparam logic [7:0] CORE_STATUS_WR_MASK = 8'he7;
   // ALU flag bits, suppressed for flag-updating writes
   localparam logic [7:0] ALU_FLAG_MASK = 8'h07;

   // Program page encodings
   localparam logic [1:0] PAGE_0 = 2'h0;
   localparam logic [1:0] PAGE_1 = 2'h1;
   localparam logic [1:0] PAGE_2 = 2'h2;
   localparam logic [1:0] PAGE_RESERVED = 2'h3;
   localparam int JUMP_TARGET_W = 9;
   localparam int PROG_ADDR_W = 11;
   localparam int NIBBLE_W = 4;

   // ALU operations that touch the flags, and ALU_NONE for none
   typedef enum logic [1:0] {
      ALU_NONE = 2'b00,
      ALU_ADD = 2'b01,
      ALU_SUB = 2'b10,
      ALU_LOGIC = 2'b11
   } csr_alu_op_t;

   // Cause reported with a non-power-up reset
   typedef enum logic [1:0] {
      CAUSE_EXTERNAL = 2'b00,
      CAUSE_WATCHDOG = 2'b01,
      CAUSE_PIN_WAKE = 2'b10
   } csr_rst_cause_t;

   typedef struct packed {
      logic valid;
      csr_alu_op_t op;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] logic_res;
   } csr_alu_req_t;

   typedef struct packed {
      logic zero;
      logic nibble_carry;
      logic carry;
      logic [7:0] result;
   } csr_alu_flags_t;

   typedef struct packed {
      logic watchdog_kick_instr;
      logic sleep_instr;
      logic watchdog_expire;
      logic reset_event;
      csr_rst_cause_t cause;
   } csr_core_evt_t;

endpackage
`default_nettype wire

// ### hdl/csr_alu_flags.sv
// Flag computation for add, subtract and logic results
`timescale 1ns/1ps
`default_nettype none

module csr_alu_flags (
   input wire csr_pkg::csr_alu_req_t req,     // Operation and operands
   output var csr_pkg::csr_alu_flags_t flags  // Result and its flags
);

   logic [8:0] sum;
   logic [4:0] nib_sum;

   // Subtract is a + ~b + 1, so carry out means no borrow
   always_comb begin
      sum = 9'h000;
      nib_sum = 5'h00;
      flags = '0;
      case (req.op)
         csr_pkg::ALU_ADD: begin
            sum = {1'b0, req.a} + {1'b0, req.b};
            nib_sum = {1'b0, req.a[3:0]} + {1'b0, req.b[3:0]};
            flags.result = sum[7:0];
            flags.carry = sum[8];
            flags.nibble_carry = nib_sum[csr_pkg::NIBBLE_W];   // [R10]
         end
         csr_pkg::ALU_SUB: begin
            sum = {1'b0, req.a} + {1'b0, ~req.b} + 9'h001;
            nib_sum = {1'b0, req.a[3:0]} + {1'b0, ~req.b[3:0]} + 5'h01;
            flags.result = sum[7:0];
            flags.carry = sum[8];
            flags.nibble_carry = nib_sum[csr_pkg::NIBBLE_W];   // [R11]
         end
         csr_pkg::ALU_LOGIC: begin
            flags.result = req.logic_res;
         end
         default: begin
            flags.result = 8'h00;
         end
      endcase
      flags.zero = (flags.result == 8'h00);                   // [R09]
   end

endmodule

`default_nettype wire

// ### hdl/csr_top.sv
// Core status register with ALU flags, page select, reset causes, AXI4-Lite access
//
// Behaviour
// R01: Pin-change wake flag is set by a reset caused by pin-change wake-up.
// R02: Pin-change wake flag clears after power-up and any other reset cause.
// R03: Page select 00, 01, 10 pick pages at 000h, 200h, 400h.
// R04: Software must never write page select 11; that code is reserved.
// R05: Time-out flag sets on power-up, watchdog kick and sleep.
// R06: Time-out flag clears when the watchdog timer expires.
// R07: Power-down flag sets on power-up and watchdog kick.
// R08: Power-down flag clears whenever sleep executes.
// R09: Zero flag follows whether an ALU result is zero.
// R10: On add, nibble carry is the carry out of bit three.
// R11: On subtract, nibble carry is one when no borrow leaves bit three.
// R12: Flag-updating writes leave zero, nibble, carry to ALU; time-out, power-down read-only.
// R13: Page select forms upper jump and call address bits; resets to page zero.
`timescale 1ns/1ps
`default_nettype none

module csr_top (
   input wire logic aclk,                                      // Core clock, 40 MHz
   input wire logic aresetn,                                   // Power-up reset, active low
   // AXI4-Lite slave
   input wire logic [csr_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,    // Write address
   input wire logic s_axi_awvalid,                             // Write address valid
   output logic s_axi_awready,                                 // Write address ready
   input wire logic [csr_pkg::AXI_DATA_W-1:0] s_axi_wdata,     // Write data
   input wire logic [3:0] s_axi_wstrb,                         // Byte enables
   input wire logic s_axi_wvalid,                              // Write data valid
   output logic s_axi_wready,                                  // Write data ready
   output logic [1:0] s_axi_bresp,                             // Write response
   output logic s_axi_bvalid,                                  // Write response valid
   input wire logic s_axi_bready,                              // Write response ready
   input wire logic [csr_pkg::AXI_ADDR_W-1:0] s_axi_araddr,    // Read address
   input wire logic s_axi_arvalid,                             // Read address valid
   output logic s_axi_arready,                                 // Read address ready
   output logic [csr_pkg::AXI_DATA_W-1:0] s_axi_rdata,         // Read data
   output logic [1:0] s_axi_rresp,                             // Read response
   output logic s_axi_rvalid,                                  // Read data valid
   input wire logic s_axi_rready,                              // Read data ready
   // Core side
   input wire csr_pkg::csr_alu_req_t alu_req,                  // ALU op updating flags
   input wire csr_pkg::csr_core_evt_t core_evt,                // Watchdog, sleep, reset events
   input wire logic core_wr_en,                                // Instruction writes this register
   input wire logic [7:0] core_wr_data,                        // Value written by the core
   input wire logic jump_valid,                                // Jump or call target strobe
   input wire logic [csr_pkg::JUMP_TARGET_W-1:0] jump_target,  // Low target bits
   output logic [7:0] core_status,                             // Register contents
   output logic [1:0] program_page_select,                     // Current page
   output logic [csr_pkg::PROG_ADDR_W-1:0] jump_addr,          // Full jump or call address
   output logic [7:0] alu_result                               // Last ALU result
);

   csr_pkg::csr_alu_flags_t alu_flags;

   // Flag arithmetic kept apart so the core datapath can reuse it
   csr_alu_flags u_alu_flags (
      .req(alu_req),
      .flags(alu_flags)
   );

   // ---------------- Bus write channel ----------------
   logic aw_held_r, aw_held_nxt;
   logic w_held_r, w_held_nxt;
   logic [csr_pkg::AXI_ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [7:0] wdata_r, wdata_nxt;
   logic wstrb0_r, wstrb0_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic bus_wr_fire;
   logic bus_wr_hit;

   assign s_axi_awready = !aw_held_r && !bvalid_r;
   assign s_axi_wready = !w_held_r && !bvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;

   // Address and data taken in either order, write done once both are held
   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb0_nxt = wstrb0_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      bus_wr_fire = 1'b0;
      bus_wr_hit = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_held_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata[7:0];
         wstrb0_nxt = s_axi_wstrb[0];
      end
      if (aw_held_r && w_held_r) begin
         bus_wr_fire = 1'b1;
         bus_wr_hit = (awaddr_r == csr_pkg::CORE_STATUS_ADDR) && wstrb0_r;
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = (awaddr_r == csr_pkg::CORE_STATUS_ADDR) ? csr_pkg::AXI_RESP_OKAY
                                                             : csr_pkg::AXI_RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
   end

   // Write channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= 8'h00;
         wdata_r <= 8'h00;
         wstrb0_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= csr_pkg::AXI_RESP_OKAY;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb0_r <= wstrb0_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   // ---------------- Bus read channel ----------------
   logic rvalid_r, rvalid_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [7:0] status_r, status_nxt;

   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = {24'h000000, rdata_r};
   assign s_axi_rresp = rresp_r;

   // One read in flight; unmapped reads answer zero with an error
   always_comb begin
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         if (s_axi_araddr == csr_pkg::CORE_STATUS_ADDR) begin
            rdata_nxt = status_r;
            rresp_nxt = csr_pkg::AXI_RESP_OKAY;
         end else begin
            rdata_nxt = 8'h00;
            rresp_nxt = csr_pkg::AXI_RESP_SLVERR;
         end
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // Read channel registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r <= 8'h00;
         rresp_r <= csr_pkg::AXI_RESP_OKAY;
      end else begin
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // ---------------- Status register ----------------
   logic [7:0] wr_val;
   logic [7:0] wr_mask;
   logic alu_upd;

   // Plain writes first, core after bus, then hardware events on top
   always_comb begin
      status_nxt = status_r;
      wr_val = 8'h00;
      wr_mask = 8'h00;
      alu_upd = alu_req.valid && (alu_req.op != csr_pkg::ALU_NONE);
      if (bus_wr_hit) begin
         wr_val = wdata_r;
         wr_mask = csr_pkg::CORE_STATUS_WR_MASK;
      end
      if (core_wr_en) begin
         wr_val = core_wr_data;
         wr_mask = csr_pkg::CORE_STATUS_WR_MASK;
      end
      if (alu_upd) begin
         wr_mask = wr_mask & ~csr_pkg::ALU_FLAG_MASK;            // [R12]
      end
      // Time-out and power-down stay out of the write mask
      status_nxt = (status_r & ~wr_mask) | (wr_val & wr_mask);   // [R12]
      if (alu_upd) begin
         status_nxt[csr_pkg::ZERO_BIT] = alu_flags.zero;         // [R09]
         if (alu_req.op != csr_pkg::ALU_LOGIC) begin
            status_nxt[csr_pkg::NIBBLE_BIT] = alu_flags.nibble_carry; // [R10] [R11]
            status_nxt[csr_pkg::CARRY_BIT] = alu_flags.carry;
         end
      end
      if (core_evt.watchdog_kick_instr) begin
         status_nxt[csr_pkg::TIMEOUT_BIT] = 1'b1;                // [R05]
         status_nxt[csr_pkg::POWERDOWN_BIT] = 1'b1;              // [R07]
      end
      if (core_evt.sleep_instr) begin
         status_nxt[csr_pkg::TIMEOUT_BIT] = 1'b1;                // [R05]
         status_nxt[csr_pkg::POWERDOWN_BIT] = 1'b0;              // [R08]
      end
      // Expiry last so a time-out is never masked by a same-cycle kick
      if (core_evt.watchdog_expire) begin
         status_nxt[csr_pkg::TIMEOUT_BIT] = 1'b0;                // [R06]
      end
      // A reset event beats any write, so the cause is never lost
      if (core_evt.reset_event) begin
         status_nxt[csr_pkg::WAKE_BIT] =
            (core_evt.cause == csr_pkg::CAUSE_PIN_WAKE);         // [R01] [R02]
         status_nxt[csr_pkg::PAGE_HI_BIT] = 1'b0;                // [R13]
         status_nxt[csr_pkg::PAGE_LO_BIT] = 1'b0;
      end
   end

   // Power-up loads wake clear, page zero, TO and PD set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         status_r <= csr_pkg::CORE_STATUS_RESET;                 // [R02] [R05] [R07] [R13]
      end else begin
         status_r <= status_nxt;
      end
   end

   assign core_status = status_r;
   assign program_page_select = status_r[csr_pkg::PAGE_HI_BIT:csr_pkg::PAGE_LO_BIT];

   // ---------------- Jump address and ALU result ----------------
   logic [csr_pkg::PROG_ADDR_W-1:0] jump_addr_r, jump_addr_nxt;
   logic [7:0] alu_result_r, alu_result_nxt;

   // Page bits on top of the target; reserved code passed through unchanged
   always_comb begin
      jump_addr_nxt = jump_addr_r;
      alu_result_nxt = alu_result_r;
      if (jump_valid) begin
         jump_addr_nxt = {program_page_select, jump_target};    // [R03] [R13]
      end
      if (alu_upd) begin
         alu_result_nxt = alu_flags.result;
      end
   end

   // Datapath output registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         jump_addr_r <= 11'h000;
         alu_result_r <= 8'h00;
      end else begin
         jump_addr_r <= jump_addr_nxt;
         alu_result_r <= alu_result_nxt;
      end
   end

   assign jump_addr = jump_addr_r;
   assign alu_result = alu_result_r;

endmodule

`default_nettype wire

// ### tb/csr_core_model.sv
// Core-side model: ALU, watchdog and reset logic issuing one-cycle pulses
`timescale 1ns/1ps
`default_nettype none
module csr_core_model (
   input wire logic aclk, // Core clock
   input wire logic go, // Issue one step
   input wire csr_pkg::csr_alu_req_t alu_in, // Op to issue
   input wire csr_pkg::csr_core_evt_t evt_in, // Events to issue
   input wire logic we_in, // Core write wanted
   input wire logic [7:0] wd_in, // Core write value
   input wire logic jv_in, // Jump wanted
   input wire logic [8:0] jt_in, // Jump low bits
   output var csr_pkg::csr_alu_req_t alu_req, // Op to the register
   output var csr_pkg::csr_core_evt_t core_evt, // Events to the register
   output logic core_wr_en, // Core write strobe
   output logic [7:0] core_wr_data, // Core write value
   output logic jump_valid, // Jump strobe
   output logic [8:0] jump_target // Jump low bits
);
   // Strobes last one cycle; idle data flips so stale values are never trusted
   always_ff @(posedge aclk) begin
      alu_req <= go ? alu_in : csr_pkg::csr_alu_req_t'({1'h0, ~alu_req[25:0]});
      core_evt <= go ? evt_in : '0;
      core_wr_en <= go & we_in;
      core_wr_data <= go ? wd_in : ~core_wr_data;
      jump_valid <= go & jv_in;
      jump_target <= go ? jt_in : ~jump_target;
   end
endmodule
`default_nettype wire

// ### tb/csr_top_monitor.sv
// Concurrent checks on the core status register ports
`timescale 1ns/1ps
`default_nettype none
module csr_top_monitor (
   input wire logic aclk, // Core clock
   input wire logic aresetn, // Sync reset, active low
   input wire csr_pkg::csr_alu_req_t alu_req, // ALU op
   input wire csr_pkg::csr_core_evt_t core_evt, // Core events
   input wire logic jump_valid, // Jump strobe
   input wire logic [8:0] jump_target, // Jump low bits
   input wire logic [7:0] core_status, // Register contents
   input wire logic [1:0] program_page_select, // Current page
   input wire logic [10:0] jump_addr, // Full jump address
   input wire logic [7:0] alu_result // Last ALU result
);
   // Expected nibble flag, kept beside the op so the check sees the operands
   logic nib_exp_r;
   always_ff @(posedge aclk) begin
      nib_exp_r <= (alu_req.op == csr_pkg::ALU_ADD) ?
         (({1'h0, alu_req.a[3:0]} + {1'h0, alu_req.b[3:0]}) > 5'h0f) :
         (alu_req.a[3:0] >= alu_req.b[3:0]);
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   rst_value_a: assert property (
      disable iff (1'h0) !aresetn |=> core_status == 8'h18 && jump_addr == 11'h000)
      else $error("reset value wrong");
   wake_set_a: assert property (
      core_evt.reset_event && core_evt.cause == csr_pkg::CAUSE_PIN_WAKE
      |=> core_status[7] && program_page_select == 2'h0)
      else $error("wake flag not set");
   wake_clr_a: assert property (
      core_evt.reset_event && core_evt.cause != csr_pkg::CAUSE_PIN_WAKE |=> !core_status[7])
      else $error("wake flag not cleared");
   kick_flags_a: assert property (
      core_evt.watchdog_kick_instr && !core_evt.sleep_instr && !core_evt.watchdog_expire
      |=> core_status[4:3] == 2'h3)
      else $error("kick did not set flags");
   sleep_pd_a: assert property (
      core_evt.sleep_instr && !core_evt.watchdog_kick_instr |=> !core_status[3])
      else $error("sleep did not clear power-down");
   expire_to_a: assert property (core_evt.watchdog_expire |=> !core_status[4])
      else $error("expiry did not clear time-out");
   zero_flag_a: assert property (
      alu_req.valid && alu_req.op != csr_pkg::ALU_NONE
      |=> core_status[2] == (alu_result == 8'h00))
      else $error("zero flag wrong");
   nibble_flag_a: assert property (
      alu_req.valid && (alu_req.op == csr_pkg::ALU_ADD || alu_req.op == csr_pkg::ALU_SUB)
      |=> core_status[1] == nib_exp_r)
      else $error("nibble carry wrong");
   jump_page_a: assert property (
      jump_valid |=> jump_addr == {$past(program_page_select), $past(jump_target)})
      else $error("jump address wrong");
   flags_ro_a: assert property (
      !(core_evt.watchdog_kick_instr || core_evt.sleep_instr || core_evt.watchdog_expire)
      |=> $stable(core_status[4:3]))
      else $error("time-out or power-down moved");

   // Main scenarios reached
   cover property (core_evt.reset_event && core_evt.cause == csr_pkg::CAUSE_PIN_WAKE);
   cover property (jump_valid && program_page_select == 2'h2);
   cover property (core_evt.sleep_instr);
endmodule

bind csr_top csr_top_monitor i_mon (.aclk(aclk), .aresetn(aresetn), .alu_req(alu_req),
   .core_evt(core_evt), .jump_valid(jump_valid), .jump_target(jump_target),
   .core_status(core_status), .program_page_select(program_page_select),
   .jump_addr(jump_addr), .alu_result(alu_result));
`default_nettype wire

// ### tb/csr_top_test.sv
// Self-checking bench for the core status register
`timescale 1ns/1ps
`default_nettype none
module csr_top_test;
   typedef struct packed {csr_pkg::csr_alu_req_t alu; logic [5:0] ev; logic [7:0] exp;} csr_row_t;
   logic aclk = 1'h0, aresetn = 1'h0, go = 1'h0, we = 1'h0, jv = 1'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0] awaddr = 8'h00, araddr = 8'h00, wd = 8'h00;
   logic [3:0] wstrb = 4'hf;
   logic [31:0] wdata = 32'h0, d;
   logic [8:0] jt = 9'h000;
   logic [1:0] rsp;
   csr_pkg::csr_alu_req_t alu_in = '0;
   csr_pkg::csr_core_evt_t evt_in = '0;
   wire logic awready, wready, bvalid, arready, rvalid, cwe, jvo;
   wire logic [1:0] bresp, rresp, page;
   wire logic [31:0] rdata;
   wire logic [7:0] status, cwd, alu_res;
   wire logic [8:0] cjt;
   wire logic [10:0] jaddr;
   wire csr_pkg::csr_alu_req_t alu_req;
   wire csr_pkg::csr_core_evt_t core_evt;
   int num_errors = 0, samples_checked = 0;
   csr_row_t rows[10];

   csr_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .alu_req(alu_req), .core_evt(core_evt), .core_wr_en(cwe), .core_wr_data(cwd),
      .jump_valid(jvo), .jump_target(cjt), .core_status(status), .program_page_select(page),
      .jump_addr(jaddr), .alu_result(alu_res));
   csr_core_model i_core (.aclk(aclk), .go(go), .alu_in(alu_in), .evt_in(evt_in), .we_in(we),
      .wd_in(wd), .jv_in(jv), .jt_in(jt), .alu_req(alu_req), .core_evt(core_evt),
      .core_wr_en(cwe), .core_wr_data(cwd), .jump_valid(jvo), .jump_target(cjt));

   // 40 MHz core clock
   initial forever #12.5 aclk = ~aclk;

   function automatic csr_pkg::csr_alu_req_t op(input logic [1:0] o, input logic [7:0] a, b, r);
      return '{o != 2'h0, csr_pkg::csr_alu_op_t'(o), a, b, r};
   endfunction

   task automatic check(input logic [31:0] got, exp);
      samples_checked++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic tally_and_finish();
      $display("errors=%0d checks=%0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   // One core step: model pulses for a cycle, register shows it one edge later
   task automatic core_op(input csr_pkg::csr_alu_req_t a, input logic [5:0] e, input logic w,
      input logic [7:0] v, input logic j, input logic [8:0] t);
      @(posedge aclk);
      go <= 1'h1;
      alu_in <= a;
      evt_in <= csr_pkg::csr_core_evt_t'(e);
      we <= w;
      wd <= v;
      jv <= j;
      jt <= t;
      @(posedge aclk);
      go <= 1'h0;
      @(posedge aclk);
      @(negedge aclk);
   endtask

   // Ready is sampled mid-cycle, where it has settled, and acted on at the next edge
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
      logic ha, hw, hb;
      ha = 1'h0;
      hw = 1'h0;
      @(posedge aclk);
      awaddr <= a;
      wdata <= v;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      while (!(ha && hw)) begin
         @(negedge aclk);
         ha = ha | awready;
         hw = hw | wready;
         @(posedge aclk);
         if (ha) awvalid <= 1'h0;
         if (hw) wvalid <= 1'h0;
      end
      bready <= 1'h1;
      do begin
         @(negedge aclk);
         hb = bvalid;
         rsp = bresp;
         @(posedge aclk);
      end while (!hb);
      bready <= 1'h0;
   endtask

   task automatic axi_rd(input logic [7:0] a);
      logic h;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      do begin
         @(negedge aclk);
         h = arready;
         @(posedge aclk);
      end while (!h);
      arvalid <= 1'h0;
      rready <= 1'h1;
      do begin
         @(negedge aclk);
         h = rvalid;
         d = rdata;
         rsp = rresp;
         @(posedge aclk);
      end while (!h);
      rready <= 1'h0;
   endtask

   // Hang guard, far beyond the hundred or so cycles the tests need
   initial begin
      repeat (5000) @(posedge aclk);
      num_errors++;
      tally_and_finish();
   end

   initial begin
      // Ordinary cases: ALU op or core event, then the whole register
      rows = '{'{op(2'h1, 8'h0f, 8'h01, 8'h00), 6'h00, 8'h1a},
         '{op(2'h1, 8'hf0, 8'h10, 8'h00), 6'h00, 8'h1d},
         '{op(2'h2, 8'h10, 8'h01, 8'h00), 6'h00, 8'h19},
         '{op(2'h2, 8'h05, 8'h03, 8'h00), 6'h00, 8'h1b},
         '{op(2'h3, 8'h00, 8'h00, 8'h00), 6'h00, 8'h1f},
         '{op(2'h0, 8'h00, 8'h00, 8'h00), 6'h10, 8'h17},
         '{op(2'h0, 8'h00, 8'h00, 8'h00), 6'h08, 8'h07},
         '{op(2'h0, 8'h00, 8'h00, 8'h00), 6'h20, 8'h1f},
         '{op(2'h0, 8'h00, 8'h00, 8'h00), 6'h06, 8'h9f},
         '{op(2'h0, 8'h00, 8'h00, 8'h00), 6'h04, 8'h1f}};
      repeat (12) @(posedge aclk);
      check(status, 8'h18);
      check(jaddr, 11'h000);
      aresetn <= 1'h1;
      foreach (rows[i]) begin
         core_op(rows[i].alu, rows[i].ev, 1'h0, 8'h00, 1'h0, 9'h000);
         check(status, rows[i].exp);
      end
      // Page codes kept to 00, 01, 10; flag bits 4:3 hold against writes
      axi_wr(8'h00, 32'h20);
      check(rsp, csr_pkg::AXI_RESP_OKAY);
      check(status, 8'h38);
      check(page, 2'h1);
      axi_rd(8'h00);
      check(d, 32'h38);
      check(rsp, csr_pkg::AXI_RESP_OKAY);
      core_op(op(2'h0, 8'h00, 8'h00, 8'h00), 6'h00, 1'h0, 8'h00, 1'h1, 9'h1a5);
      check(jaddr, 11'h3a5);
      axi_wr(8'h00, 32'h40);
      core_op(op(2'h0, 8'h00, 8'h00, 8'h00), 6'h00, 1'h0, 8'h00, 1'h1, 9'h000);
      check(jaddr, 11'h400);
      axi_wr(8'h00, 32'h00);
      check(status, 8'h18);
      // Core write racing a flag-updating add: the ALU keeps the low three bits
      core_op(op(2'h1, 8'hff, 8'h01, 8'h00), 6'h00, 1'h1, 8'h40, 1'h0, 9'h000);
      check(status, 8'h5f);
      axi_rd(8'h04);
      check(d, 32'h0);
      check(rsp, csr_pkg::AXI_RESP_SLVERR);
      axi_wr(8'h04, 32'hff);
      check(rsp, csr_pkg::AXI_RESP_SLVERR);
      check(status, 8'h5f);
      // Low byte strobe off: answered, register left alone
      wstrb <= 4'he;
      axi_wr(8'h00, 32'h20);
      wstrb <= 4'hf;
      check(rsp, csr_pkg::AXI_RESP_OKAY);
      check(status, 8'h5f);
      core_op(op(2'h0, 8'h00, 8'h00, 8'h00), 6'h06, 1'h0, 8'h00, 1'h0, 9'h000);
      check(status, 8'h9f);
      // Nonzero result so the reset below has something to clear
      core_op(op(2'h2, 8'h35, 8'h12, 8'h00), 6'h00, 1'h0, 8'h00, 1'h0, 9'h000);
      check(status, 8'h9b);
      check(alu_res, 8'h23);
      // Power-up reset in mid-run clears wake, ALU flags, jump address and result
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (2) @(posedge aclk);
      check(status, 8'h18);
      check(jaddr, 11'h000);
      check(alu_res, 8'h00);
      aresetn <= 1'h1;
      @(posedge aclk);
      tally_and_finish();
   end
endmodule
`default_nettype wire
